// file: tb/sfc_host_model.sv
// Host serial master model that drives the flash link in mode 0.
`timescale 1ns/1ps
`default_nettype none

module sfc_host_model (
	// Link toward the device.
	output var logic sck,
	output var logic cs_n,
	output var logic si,
	input wire logic so_o
);
	// The link clock stands low and the select high outside frames.
	initial begin
		sck = 1'b0;
		cs_n = 1'b0;
		si = 1'b1;
		// The frame logic has no reset but the select itself, so one
		// clean rising edge at start clears it before anyone looks.
		#1;
		cs_n = 1'b1;
	end

	// Select the device; no clock edge comes until the first bit.
	task automatic start();
		cs_n = 1'b0;
		#3;
	endtask

	// One byte each way, MSB first, on a 6 ns link clock.
	// Read data is taken at the rising edge, half a period after the
	// device changed it on the falling edge, so it is settled.
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			si = tx[i];
			#3;
			sck = 1'b1;
			rx[i] = so_o;
			#3;
			sck = 1'b0;
		end
	endtask

	// Deselect, flip the released data line, and keep the select high
	// long enough for the system clock side to see the gap.
	task automatic stop();
		#3;
		cs_n = 1'b1;
		si = ~si;
		#200;
	endtask
endmodule

`default_nettype wire

// file: tb/test_serial_flash_read_buffer_cmds.sv
// Self-checking testbench for the serial flash command sequencer.
`timescale 1ns/1ps
`default_nettype none

module test_serial_flash_read_buffer_cmds;
	// System side of the device.
	logic clk_sys;
	logic resetn;
	logic page_bin;
	logic cell_fault;
	logic so_o;
	logic so_oe;
	logic busy;
	logic erase_program_error_flag;
	// What the host sees: a released output shows the inverse of the
	// last bit, so a bit taken while undriven cannot match by chance.
	logic so_line;
	// Link driven by the host model.
	wire sck;
	wire cs_n;
	wire si;
	// Counters, expected buffer and expected page contents.
	int fail_count;
	int cmp_count;
	int bsz;
	logic [7:0] eb [264];
	logic [7:0] exp_pg [2][264];

	// A two-page array keeps the wrap checks short.
	sfc_flash_seq #(.PAGES(2)) DUT (
		.clk_sys(clk_sys), .resetn(resetn), .sck(sck), .cs_n(cs_n),
		.si(si), .so_o(so_o), .so_oe(so_oe), .page_bin(page_bin),
		.cell_fault(cell_fault), .busy(busy),
		.erase_program_error_flag(erase_program_error_flag)
	);

	assign so_line = so_oe ? so_o : ~so_o;

	sfc_host_model host (.sck(sck), .cs_n(cs_n), .si(si), .so_o(so_line));

	// The 25 MHz system clock.
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end

	// Compare one value and count it.
	task automatic check(input logic [7:0] seen, input logic [7:0] want);
		cmp_count++;
		if (seen !== want) begin
			fail_count++;
			$display("mismatch at %0t: saw %h want %h", $time, seen, want);
		end
	endtask

	// Print the counts and the verdict, then end the run.
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// Opcode and three address bytes.
	task automatic cmd(input logic [7:0] op, input logic [23:0] a);
		logic [7:0] d;
		host.start();
		host.xfer(op, d);
		for (int i = 2; i >= 0; i--) begin
			host.xfer(a[8*i+:8], d);
		end
	endtask

	// Write n bytes from offset off; byte j gets base plus 7*j.
	task automatic buf_write(input int off, input int n, input logic [7:0] base);
		logic [7:0] d;
		int j;
		cmd(8'h84, 24'hC0_0000 | 24'(off));
		for (int k = 0; k < n; k++) begin
			j = (off + k) % bsz;
			eb[j] = base + 8'(j * 7);
			host.xfer(eb[j], d);
		end
		host.stop();
	endtask

	// Read command with dummies, then compare the streamed bytes.
	task automatic read_cmp(input logic [7:0] op, input logic [23:0] a,
			input int ndum, input logic [7:0] want [$]);
		logic [7:0] d;
		cmd(op, a);
		repeat (ndum) host.xfer(8'h00, d);
		// The enable is launched by the fall that ended the last byte;
		// step past that instant before looking at it.
		#1;
		check({7'h0, so_oe}, 8'h01);
		foreach (want[k]) begin
			host.xfer(8'h00, d);
			check(d, want[k]);
		end
		host.stop();
		check({7'h0, so_oe}, 8'h00);
	endtask

	// Program a page from the buffer and follow the busy flag.
	task automatic prog_page(input int pg, input logic err);
		int t;
		cmd(8'h83, 24'h80_0000 | (24'(pg) << (page_bin ? 8 : 9)));
		host.stop();
		t = 0;
		while (busy !== 1'b1 && t < 100) begin
			@(posedge clk_sys);
			t++;
		end
		check({7'h0, busy}, 8'h01);
		t = 0;
		while (busy === 1'b1 && t < 5000) begin
			@(posedge clk_sys);
			t++;
		end
		check({7'h0, busy}, 8'h00);
		check(8'(t >= 4 * bsz), 8'h01);
		check({7'h0, erase_program_error_flag}, {7'h0, err});
		// A failed job leaves the page as it was, so only a good one
		// moves the expected contents.
		if (!err) begin
			for (int j = 0; j < bsz; j++) begin
				exp_pg[pg][j] = eb[j];
			end
		end
	endtask

	// Buffer fill with wrap, both buffer reads, and a refused opcode.
	task automatic test_buffer();
		logic [7:0] d;
		buf_write(260, 264, 8'h03);
		read_cmp(8'hD1, 24'hC0_0000 | 24'd262, 0,
			{eb[262], eb[263], eb[0], eb[1]});
		read_cmp(8'hD4, 24'd5, 1, {eb[5], eb[6]});
		cmd(8'h00, 24'd0);
		host.xfer(8'h00, d);
		#1;
		check({7'h0, so_oe}, 8'h00);
		host.stop();
		$display("test buffer done");
	endtask

	// Fill both pages with different data.
	task automatic test_program();
		prog_page(0, 1'b0);
		buf_write(0, 264, 8'h40);
		prog_page(1, 1'b0);
		$display("test program done");
	endtask

	// Page crossing, array wrap, page wrap, buffer left alone.
	task automatic test_array_read();
		read_cmp(8'h01, 24'h80_0000 | 24'h00_0200 | 24'd262, 0,
			{exp_pg[1][262], exp_pg[1][263], exp_pg[0][0]});
		read_cmp(8'h01, 24'd263, 0, {exp_pg[0][263], exp_pg[1][0]});
		read_cmp(8'hD2, 24'd263, 4, {exp_pg[0][263], exp_pg[0][0]});
		read_cmp(8'hD1, 24'd100, 0, {eb[100]});
		$display("test array read done");
	endtask

	// A stuck cell makes verify fail.
	task automatic test_fault();
		@(posedge clk_sys);
		cell_fault <= 1'b1;
		repeat (3) @(posedge clk_sys);
		prog_page(0, 1'b1);
		@(posedge clk_sys);
		cell_fault <= 1'b0;
		repeat (3) @(posedge clk_sys);
		$display("test fault done");
	endtask

	// Binary pages: buffer wrap at 256, program, page read wrap.
	task automatic test_binary();
		@(posedge clk_sys);
		page_bin <= 1'b1;
		repeat (3) @(posedge clk_sys);
		bsz = 256;
		buf_write(254, 3, 8'h11);
		read_cmp(8'hD1, 24'd255, 0, {eb[255], eb[0]});
		prog_page(1, 1'b0);
		read_cmp(8'hD2, 24'h00_0100 | 24'd255, 4,
			{exp_pg[1][255], exp_pg[1][0]});
		$display("test binary done");
	endtask

	// Main sequence.
	initial begin
		resetn = 1'b0;
		page_bin = 1'b0;
		cell_fault = 1'b0;
		fail_count = 0;
		cmp_count = 0;
		bsz = 264;
		repeat (10) @(posedge clk_sys);
		resetn <= 1'b1;
		repeat (5) @(posedge clk_sys);
		check({5'h0, busy, erase_program_error_flag, so_oe}, 8'h00);
		test_buffer();
		test_program();
		test_array_read();
		test_fault();
		test_binary();
		print_verdict();
	end

	// Four jobs take about 0.2 ms; allow about five times that.
	initial begin
		#1_000_000;
		fail_count++;
		$display("mismatch at %0t: watchdog expired", $time);
		print_verdict();
	end
endmodule

`default_nettype wire

// file: verilog/sfc_flash_seq.sv
// Serial flash command sequencer: reads, buffer access, erase/program.
`timescale 1ns/1ps
`default_nettype none

// How it works
// (R1) Opcode 01h, three address bytes, then data.
// (R2) Standard mode: ten page bits, nine byte bits.
// (R3) Binary mode: ten page bits, eight byte bits.
// (R4) Continuous read runs into next page seamlessly.
// (R5) After the last page it restarts at zero.
// (R6) Host keeps select low for whole command.
// (R7) Select high ends read, output floats.
// (R8) Array reads never change the buffer.
// (R9) Opcode D2h, address, four dummy bytes, data.
// (R10) Page read wraps within the same page.
// (R11) Any of 1024 pages may be read.
// (R12) D4h needs one dummy byte; D1h none.
// (R13) Buffer offset nine or eight low bits.
// (R14) Buffer read wraps to its first byte.
// (R15) Opcode 84h writes buffer from given offset.
// (R16) Buffer write stores bytes, wrapping, until deselect.
// (R17) Opcode 83h carries the target page number.
// (R18) On deselect: erase page, then program buffer.
// (R19) Busy shows throughout erase and program.
// (R20) Failed erase or program sets error flag.
// (R21) Address bits above the fields are ignored.
module sfc_flash_seq #(
	parameter int PAGES = sfc_pkg::MAX_PAGES
) (
	// System clock and reset.
	input wire logic clk_sys,
	input wire logic resetn,
	// Serial link from the host.
	input wire logic sck,
	input wire logic cs_n,
	input wire logic si,
	output logic so_o,
	output logic so_oe,
	// Configuration and test pins.
	input wire logic page_bin,
	input wire logic cell_fault,
	// Status pins.
	output logic busy,
	output logic erase_program_error_flag
);
	// Array size; pages sit on a 264-byte pitch in both modes.
	localparam int MEM_BYTES = PAGES * sfc_pkg::PAGE_STD;
	localparam int IDX_W = $clog2(MEM_BYTES);

	// The page wrap logic needs a power of two no larger than the field.
	if (PAGES < 2 || PAGES > sfc_pkg::MAX_PAGES ||
		(PAGES & (PAGES - 1)) != 0) begin : g_chk
		$error("PAGES must be a power of two up to 1024");
	end

	// Main array and the SRAM buffer.
	logic [7:0] arr_mem [MEM_BYTES];
	logic [7:0] buf_mem [sfc_pkg::PAGE_STD];

	// Last byte offset of a page, or of the buffer, in the given mode.
	function automatic logic [8:0] last_by(input logic bin);
		last_by = bin ? 9'(sfc_pkg::PAGE_BIN - 1) :
			9'(sfc_pkg::PAGE_STD - 1);
	endfunction

	// Physical array index of a page and byte.
	function automatic logic [IDX_W-1:0] mem_idx(input logic [9:0] pg,
		input logic [8:0] by);
		mem_idx = IDX_W'(pg) * IDX_W'(sfc_pkg::PAGE_STD) + IDX_W'(by);
	endfunction

	// Split a three-byte address into page and byte fields.
	// Offsets past 263 in standard mode fold back into the page.
	function automatic logic [18:0] split(input logic [23:0] a,
		input logic bin);
		logic [9:0] pg;
		logic [8:0] by;
		if (bin) begin
			pg = a[sfc_pkg::BIN_PG_LSB +: sfc_pkg::PG_W]; // R3
			by = 9'(a[sfc_pkg::BIN_PG_LSB-1:0]); // R3 R13
		end else begin
			pg = a[sfc_pkg::STD_PG_LSB +: sfc_pkg::PG_W]; // R2
			by = a[sfc_pkg::BY_W-1:0]; // R2 R13
			if (by > last_by(1'b0)) begin
				by = by - 9'(sfc_pkg::PAGE_STD);
			end
		end
		// Upper bits are never looked at.
		split = {pg & 10'(PAGES - 1), by}; // R21 R11
	endfunction

	// Advance a streaming pointer by one byte with the given wrap.
	function automatic logic [18:0] ptr_next(input logic [9:0] pg,
		input logic [8:0] by, input logic bin,
		input sfc_pkg::sfc_wrap_t w);
		if (by < last_by(bin)) begin
			ptr_next = {pg, by + 9'h001};
		end else if (w == sfc_pkg::WR_ARRAY) begin
			// Next page, or page zero after the last one.
			ptr_next = {(pg == 10'(PAGES - 1)) ? 10'h000 :
				pg + 10'h001, 9'h000}; // R4 R5
		end else begin
			// Same page, or the buffer start.
			ptr_next = {pg, 9'h000}; // R10 R14 R16
		end
	endfunction

	// State the link enters once the address is complete.
	function automatic sfc_pkg::sfc_link_t after_addr(
		input logic [7:0] op);
		case (op)
			sfc_pkg::OP_PAGE_RD: after_addr = sfc_pkg::ST_DUMMY; // R9
			sfc_pkg::OP_BUF_RD_DUM: after_addr = sfc_pkg::ST_DUMMY; // R12
			sfc_pkg::OP_CAR_LP: after_addr = sfc_pkg::ST_RDOUT; // R1
			sfc_pkg::OP_BUF_RD: after_addr = sfc_pkg::ST_RDOUT; // R12
			sfc_pkg::OP_BUF_WR: after_addr = sfc_pkg::ST_WRIN; // R15
			default: after_addr = sfc_pkg::ST_IGN;
		endcase
	endfunction

	// Wrap rule of each streaming command.
	function automatic sfc_pkg::sfc_wrap_t wrap_of(input logic [7:0] op);
		if (op == sfc_pkg::OP_CAR_LP) begin
			wrap_of = sfc_pkg::WR_ARRAY;
		end else if (op == sfc_pkg::OP_PAGE_RD) begin
			wrap_of = sfc_pkg::WR_PAGE;
		end else begin
			wrap_of = sfc_pkg::WR_BUF;
		end
	endfunction

	// Successor of each engine state.
	function automatic sfc_pkg::sfc_eng_t eng_after(
		input sfc_pkg::sfc_eng_t s);
		case (s)
			sfc_pkg::E_ERASE: eng_after = sfc_pkg::E_EVFY;
			sfc_pkg::E_EVFY: eng_after = sfc_pkg::E_PROG;
			sfc_pkg::E_PROG: eng_after = sfc_pkg::E_PVFY;
			default: eng_after = sfc_pkg::E_IDLE;
		endcase
	endfunction

	// Reset synchroniser and the released reset copy.
	logic rst_m_r;
	logic rst_n_r;

	// Released through two flops so the system clock domain leaves reset cleanly.
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			rst_m_r <= 1'b0;
			rst_n_r <= 1'b0;
		end else begin
			rst_m_r <= 1'b1;
			rst_n_r <= rst_m_r;
		end
	end

	// Link domain: frame state, counters and shifters.
	sfc_pkg::sfc_link_t lk_st_r;
	logic [5:0] cnt_r; // Bits seen in the current field.
	logic [23:0] sh_r; // Serial input shifter.
	logic [7:0] op_r; // Opcode of this frame.
	logic [9:0] pg_r; // Streaming page pointer.
	logic [8:0] by_r; // Streaming byte pointer.
	logic bin_m_r; // Page mode, first sync stage.
	logic bin_r; // Page mode, synchronised.
	logic [7:0] osh_r; // Output shifter, falling edge.
	logic so_oe_r; // Output driven.
	logic prg_tgl_r; // Toggles for each program request.
	logic [9:0] prg_pg_r; // Page of the last program request.
	logic prg_bin_r; // Page mode of that request.

	// Decodes used by several processes.
	wire logic [23:0] in_w = {sh_r[22:0], si};
	wire logic addr_end = lk_st_r == sfc_pkg::ST_ADDR &&
		cnt_r == 6'(sfc_pkg::ADR_BITS - 1);
	wire logic byte_end = cnt_r == 6'(sfc_pkg::BYTE_BITS - 1);
	wire logic [18:0] spl = split(in_w, bin_r);
	wire logic is_buf = op_r == sfc_pkg::OP_BUF_RD ||
		op_r == sfc_pkg::OP_BUF_RD_DUM;
	wire logic buf_we = lk_st_r == sfc_pkg::ST_WRIN && byte_end;
	wire logic [5:0] dum_last = (op_r == sfc_pkg::OP_PAGE_RD) ?
		6'(sfc_pkg::PG_RD_DUMMY - 1) : 6'(sfc_pkg::BUF_RD_DUMMY - 1);
	wire logic [7:0] rd_byte = is_buf ? buf_mem[by_r] :
		arr_mem[mem_idx(pg_r, by_r)];

	// Page mode crosses in on the link clock; eight opcode edges
	// pass before it is used, so it is settled by the address.
	always_ff @(posedge sck or posedge cs_n) begin
		if (cs_n) begin
			bin_m_r <= 1'b0;
			bin_r <= 1'b0;
		end else begin
			bin_m_r <= page_bin;
			bin_r <= bin_m_r;
		end
	end

	// Input shifter; runs on every rising edge of a frame.
	always_ff @(posedge sck or posedge cs_n) begin
		if (cs_n) begin
			sh_r <= '0;
		end else begin
			sh_r <= in_w;
		end
	end

	// Frame sequencing; deselect ends whatever is under way.
	always_ff @(posedge sck or posedge cs_n) begin
		if (cs_n) begin
			lk_st_r <= sfc_pkg::ST_OPC; // R6 R7
			cnt_r <= '0;
			op_r <= '0;
		end else begin
			cnt_r <= cnt_r + 6'h01;
			case (lk_st_r)
				sfc_pkg::ST_OPC: begin
					if (cnt_r == 6'(sfc_pkg::OPC_BITS - 1)) begin
						op_r <= in_w[7:0];
						cnt_r <= '0;
						lk_st_r <= sfc_pkg::ST_ADDR;
					end
				end
				sfc_pkg::ST_ADDR: begin
					if (addr_end) begin
						cnt_r <= '0;
						lk_st_r <= after_addr(op_r); // R1 R9 R12
					end
				end
				sfc_pkg::ST_DUMMY: begin
					if (cnt_r == dum_last) begin
						cnt_r <= '0;
						lk_st_r <= sfc_pkg::ST_RDOUT; // R9 R12
					end
				end
				sfc_pkg::ST_RDOUT, sfc_pkg::ST_WRIN: begin
					if (byte_end) begin
						cnt_r <= '0;
					end
				end
				default: begin
					// Unknown or finished command: hold still.
					cnt_r <= cnt_r;
				end
			endcase
		end
	end

	// Streaming pointer: loaded from the address, then stepped.
	always_ff @(posedge sck or posedge cs_n) begin
		if (cs_n) begin
			{pg_r, by_r} <= '0;
		end else if (addr_end) begin
			{pg_r, by_r} <= spl; // R2 R3 R13
		end else if (byte_end && (lk_st_r == sfc_pkg::ST_RDOUT ||
			lk_st_r == sfc_pkg::ST_WRIN)) begin
			{pg_r, by_r} <= ptr_next(pg_r, by_r, bin_r, wrap_of(op_r));
		end
	end

	// Only the buffer write command ever stores into the buffer.
	always_ff @(posedge sck) begin
		if (buf_we) begin
			buf_mem[by_r] <= in_w[7:0]; // R8 R16
		end
	end

	// Program request: page held, toggle marks the event.
	// The page is stable long before the toggle is seen.
	always_ff @(posedge sck or negedge rst_n_r) begin
		if (!rst_n_r) begin
			prg_tgl_r <= 1'b0;
			prg_pg_r <= '0;
			prg_bin_r <= 1'b0;
		end else if (addr_end && op_r == sfc_pkg::OP_PROG_ERASE) begin
			prg_tgl_r <= ~prg_tgl_r;
			prg_pg_r <= spl[18:9]; // R17
			prg_bin_r <= bin_r;
		end
	end

	// Output side changes on falling edges so the host samples on
	// rising ones; deselect floats the pin at once.
	always_ff @(negedge sck or posedge cs_n) begin
		if (cs_n) begin
			osh_r <= '0; // R7
			so_oe_r <= 1'b0; // R7
		end else if (lk_st_r == sfc_pkg::ST_RDOUT) begin
			so_oe_r <= 1'b1;
			if (cnt_r[2:0] == 3'h0) begin
				osh_r <= rd_byte; // R4 R8
			end else begin
				osh_r <= {osh_r[6:0], 1'b0};
			end
		end
	end

	assign so_o = osh_r[7];
	assign so_oe = so_oe_r;

	// System domain: synchronisers for select, request and fault.
	logic cs_m_r;
	logic cs_s_r;
	logic tg_m_r;
	logic tg_s_r;
	logic tg_d_r;
	logic flt_m_r;
	logic flt_s_r;

	// Two flops each, plus a third on the request for its edge; the first stage is never read by logic.
	always_ff @(posedge clk_sys or negedge rst_n_r) begin
		if (!rst_n_r) begin
			cs_m_r <= 1'b1;
			cs_s_r <= 1'b1;
			tg_m_r <= 1'b0;
			tg_s_r <= 1'b0;
			tg_d_r <= 1'b0;
			flt_m_r <= 1'b0;
			flt_s_r <= 1'b0;
		end else begin
			cs_m_r <= cs_n;
			cs_s_r <= cs_m_r;
			tg_m_r <= prg_tgl_r;
			tg_s_r <= tg_m_r;
			tg_d_r <= tg_s_r;
			flt_m_r <= cell_fault;
			flt_s_r <= flt_m_r;
		end
	end

	// Engine registers.
	sfc_pkg::sfc_eng_t eng_st_r;
	logic [8:0] idx_r; // Byte within the page being worked.
	logic [9:0] epg_r; // Page being worked.
	logic ebin_r; // Page mode of that job.
	logic pend_r; // Request seen, waiting for deselect.
	logic busy_r;
	logic err_r;

	// Engine decodes.
	wire logic start = pend_r && cs_s_r && eng_st_r == sfc_pkg::E_IDLE;
	wire logic last_i = idx_r == last_by(ebin_r);
	wire logic [IDX_W-1:0] eidx = mem_idx(epg_r, idx_r);
	wire logic [7:0] eng_rd = arr_mem[eidx];
	wire logic [7:0] eng_buf = buf_mem[idx_r];
	wire logic mism = (eng_st_r == sfc_pkg::E_EVFY &&
		eng_rd != sfc_pkg::ERASED) ||
		(eng_st_r == sfc_pkg::E_PVFY && eng_rd != eng_buf);

	// A request waits until select is seen high; a new request wins
	// over the clear.
	always_ff @(posedge clk_sys or negedge rst_n_r) begin
		if (!rst_n_r) begin
			pend_r <= 1'b0;
		end else begin
			pend_r <= (tg_s_r ^ tg_d_r) | (pend_r & ~start);
		end
	end

	// One byte per clock: erase, verify, program, verify.
	always_ff @(posedge clk_sys or negedge rst_n_r) begin
		if (!rst_n_r) begin
			eng_st_r <= sfc_pkg::E_IDLE;
			idx_r <= '0;
			epg_r <= '0;
			ebin_r <= 1'b0;
		end else begin
			case (eng_st_r)
				sfc_pkg::E_IDLE: begin
					if (start) begin
						eng_st_r <= sfc_pkg::E_ERASE; // R18
						idx_r <= '0;
						epg_r <= prg_pg_r;
						ebin_r <= prg_bin_r;
					end
				end
				default: begin
					idx_r <= last_i ? 9'h000 : idx_r + 9'h001;
					if (last_i) begin
						eng_st_r <= eng_after(eng_st_r); // R18
					end
				end
			endcase
		end
	end

	// Array writes; a stuck cell is modelled by suppressing them.
	always_ff @(posedge clk_sys) begin
		if (!flt_s_r && eng_st_r == sfc_pkg::E_ERASE) begin
			arr_mem[eidx] <= sfc_pkg::ERASED; // R18
		end else if (!flt_s_r && eng_st_r == sfc_pkg::E_PROG) begin
			arr_mem[eidx] <= eng_buf; // R18
		end
	end

	// Busy from the request until the last verify byte.
	always_ff @(posedge clk_sys or negedge rst_n_r) begin
		if (!rst_n_r) begin
			busy_r <= 1'b0;
		end else begin
			busy_r <= pend_r | (eng_st_r != sfc_pkg::E_IDLE); // R19
		end
	end

	// Error flag reports the last job; a mismatch wins over clear.
	always_ff @(posedge clk_sys or negedge rst_n_r) begin
		if (!rst_n_r) begin
			err_r <= 1'b0;
		end else if (mism) begin
			err_r <= 1'b1; // R20
		end else if (start) begin
			err_r <= 1'b0;
		end
	end

	assign busy = busy_r;
	assign erase_program_error_flag = err_r;

	// Checks on the engine.
	a_busy_engine: assert property ( // R19
		@(posedge clk_sys) disable iff (!rst_n_r)
		eng_st_r != sfc_pkg::E_IDLE |-> busy)
		else $error("engine active while ready");
	a_err_sets: assert property ( // R20
		@(posedge clk_sys) disable iff (!rst_n_r)
		mism |=> erase_program_error_flag)
		else $error("mismatch did not raise error");
	a_erase_first: assert property ( // R18
		@(posedge clk_sys) disable iff (!rst_n_r)
		start |=> eng_st_r == sfc_pkg::E_ERASE && idx_r == 9'h000)
		else $error("job did not begin with erase");
	a_so_quiet: assert property ( // R7
		@(posedge clk_sys) disable iff (!rst_n_r)
		cs_n && $past(cs_n) |-> !so_oe)
		else $error("output driven while deselected");

	// Checks on the link.
	a_page_wrap: assert property ( // R10
		@(posedge sck) disable iff (cs_n)
		lk_st_r == sfc_pkg::ST_RDOUT && byte_end &&
		op_r == sfc_pkg::OP_PAGE_RD && by_r == last_by(bin_r)
		|=> by_r == 9'h000 && pg_r == $past(pg_r))
		else $error("page read left its page");
	a_next_page: assert property ( // R4 R5
		@(posedge sck) disable iff (cs_n)
		lk_st_r == sfc_pkg::ST_RDOUT && byte_end &&
		op_r == sfc_pkg::OP_CAR_LP && by_r == last_by(bin_r)
		|=> by_r == 9'h000 && pg_r == 10'(($past(pg_r) + 10'h001) &
		10'(PAGES - 1)))
		else $error("continuous read missed next page");
	a_buf_wrap: assert property ( // R14 R16
		@(posedge sck) disable iff (cs_n)
		byte_end && (is_buf || op_r == sfc_pkg::OP_BUF_WR) &&
		lk_st_r inside {sfc_pkg::ST_RDOUT, sfc_pkg::ST_WRIN} &&
		by_r == last_by(bin_r) |=> by_r == 9'h000)
		else $error("buffer pointer did not wrap");
	a_buf_guard: assert property ( // R8
		@(posedge sck) disable iff (cs_n)
		buf_we |-> op_r == sfc_pkg::OP_BUF_WR)
		else $error("buffer written by another command");
	a_dummy_len: assert property ( // R9
		@(posedge sck) disable iff (cs_n)
		addr_end && op_r == sfc_pkg::OP_PAGE_RD |->
		##32 lk_st_r == sfc_pkg::ST_DUMMY ##1
		lk_st_r == sfc_pkg::ST_RDOUT)
		else $error("page read dummy length wrong");
	a_no_dummy: assert property ( // R1 R12
		@(posedge sck) disable iff (cs_n)
		addr_end && (op_r == sfc_pkg::OP_CAR_LP ||
		op_r == sfc_pkg::OP_BUF_RD) |=> lk_st_r == sfc_pkg::ST_RDOUT)
		else $error("data did not follow address");

	// Main scenarios.
	c_array_wrap: cover property (@(posedge sck) disable iff (cs_n)
		op_r == sfc_pkg::OP_CAR_LP && byte_end &&
		pg_r == 10'(PAGES - 1) && by_r == last_by(bin_r));
	c_buf_write: cover property (@(posedge sck) disable iff (cs_n)
		buf_we);
	c_job_done: cover property (@(posedge clk_sys)
		disable iff (!rst_n_r)
		eng_st_r == sfc_pkg::E_PVFY && last_i);
endmodule

`default_nettype wire

// file: verilog/sfc_pkg.sv
// Constants and types shared by the serial flash command sequencer.
package sfc_pkg;
	// Opcodes recognised in the first byte of a frame.
	localparam logic [7:0] OP_CAR_LP = 8'h01;
	localparam logic [7:0] OP_PAGE_RD = 8'hD2;
	localparam logic [7:0] OP_BUF_RD_DUM = 8'hD4;
	localparam logic [7:0] OP_BUF_RD = 8'hD1;
	localparam logic [7:0] OP_BUF_WR = 8'h84;
	localparam logic [7:0] OP_PROG_ERASE = 8'h83;
	// Field lengths of a frame, in serial clocks.
	localparam int OPC_BITS = 8;
	localparam int ADR_BITS = 24;
	localparam int PG_RD_DUMMY = 32;
	localparam int BUF_RD_DUMMY = 8;
	localparam int BYTE_BITS = 8;
	// Page geometry of the two page-size modes.
	localparam int PAGE_STD = 264;
	localparam int PAGE_BIN = 256;
	localparam int PG_W = 10;
	localparam int BY_W = 9;
	localparam int STD_PG_LSB = 9;
	localparam int BIN_PG_LSB = 8;
	localparam int MAX_PAGES = 1024;
	// Content of an erased byte.
	localparam logic [7:0] ERASED = 8'hFF;
	// How a streaming pointer wraps at the end of a page.
	typedef enum logic [1:0] {
		WR_ARRAY = 2'h0,
		WR_PAGE = 2'h1,
		WR_BUF = 2'h2
	} sfc_wrap_t;
	// Link states, Gray coded along opcode, address, dummy, data.
	typedef enum logic [2:0] {
		ST_OPC = 3'h0,
		ST_ADDR = 3'h1,
		ST_DUMMY = 3'h3,
		ST_RDOUT = 3'h2,
		ST_WRIN = 3'h6,
		ST_IGN = 3'h7
	} sfc_link_t;
	// Erase and program engine states, Gray coded in order.
	typedef enum logic [2:0] {
		E_IDLE = 3'h0,
		E_ERASE = 3'h1,
		E_EVFY = 3'h3,
		E_PROG = 3'h2,
		E_PVFY = 3'h6
	} sfc_eng_t;
endpackage
